/* File: rtl/urhd_pkg.sv */
// package: command codes, field layout and reset values of the root hub characteristic register
package urhd_pkg;

  // ==================================================================
  // command codes (read code has bit 7 clear, write code has it set)
  localparam logic [7:0] URHD_RD_DESC_A   = 8'h12;
  localparam logic [7:0] URHD_WR_DESC_A   = 8'h92;
  localparam logic [7:0] URHD_WR_DESC_B   = 8'h93;
  localparam logic [7:0] URHD_WR_STATUS   = 8'h94;
  localparam logic [7:0] URHD_WR_PORT1    = 8'h95;
  localparam logic [7:0] URHD_WR_PORT2    = 8'h96;

  // ==================================================================
  // field positions of the characteristic register
  localparam int unsigned URHD_WAIT_LSB   = 24;
  localparam int unsigned URHD_WAIT_MSB   = 31;
  localparam int unsigned URHD_NOOC_BIT   = 12;
  localparam int unsigned URHD_OCPP_BIT   = 11;
  localparam int unsigned URHD_CMPD_BIT   = 10;
  localparam int unsigned URHD_NOPS_BIT   = 9;
  localparam int unsigned URHD_PPPM_BIT   = 8;
  localparam int unsigned URHD_PCNT_LSB   = 0;
  localparam int unsigned URHD_PCNT_MSB   = 1;

  // ==================================================================
  // values after reset, constant field values and the writable-bit mask
  localparam logic [7:0]  URHD_WAIT_RST   = 8'hff;
  localparam logic        URHD_NOOC_RST   = 1'b0;
  localparam logic        URHD_PPPM_RST   = 1'b1;
  localparam logic        URHD_OCPP_RST   = URHD_PPPM_RST;
  localparam logic        URHD_NOPS_RST   = 1'b0;
  localparam logic        URHD_CMPD_VAL   = 1'b0;
  localparam logic [1:0]  URHD_PCNT_VAL   = 2'h2;
  localparam logic [31:0] URHD_WR_MASK    = 32'hff00_1b00;

  // ==================================================================
  // command port carriers
  typedef struct packed {
    logic        valid;
    logic [7:0]  code;
    logic [31:0] data;
  } urhd_cmd_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } urhd_rsp_type;

  // write grants toward the rest of the root hub
  typedef struct packed {
    logic        descB;
    logic        status;
    logic        port1;
    logic        port2;
  } urhd_grant_type;

endpackage : urhd_pkg

/* File: rtl/urhd_regs.sv */
// root hub characteristic register A and write gating of the root hub register group
`timescale 1ns/1ps
// What this block does
// - every root hub register moves as one whole 32-bit word.
// - descriptor A and B writes are accepted in any host controller state.
// - hub status and port status writes are accepted in the operational state.
// - hub descriptors and hub address decode live in software, not here.
// - descriptor A is read with code 12 hex and written with 92 hex.
// - bits 31..24 hold the power good wait, reset all ones, 2 ms units.
// - bit 12 set means no overcurrent reporting, clear means reported.
// - bit 11 picks collective or per-port overcurrent reporting when enabled.
// - overcurrent per-port mode resets equal to per-port power mode, both one.
// - compound device flag at bit 10 is read only and reads zero.
// - bit 9 set means ports always powered, clear means power switched.
// - bit 8 picks global or per-port power switching when switching exists.
// - per-port power mode zero powers all ports together, one individually.
// - port count in bits 1..0 is read only, reads binary 10.
module urhd_regs
  import urhd_pkg::*;
(
  input  logic           mclk,
  input  logic           sys_rst,
  input  urhd_cmd_type   cmd,
  input  logic           operationalState,
  output urhd_rsp_type   rsp,
  output urhd_grant_type grant,
  output logic [7:0]     powerGoodWaitTime,
  output logic           overcurrentReportEn,
  output logic           overcurrentPerPort,
  output logic           portsAlwaysPowered,
  output logic           perPortPowerEn,
  output logic [1:0]     downstreamPortCount
);

  // ==================================================================
  // storage of the writable fields
  logic [7:0] waitTime_q;
  logic [7:0] waitTime_d;
  logic       noOcProtect_q;
  logic       noOcProtect_d;
  logic       ocPerPortMode_q;
  logic       ocPerPortMode_d;
  logic       noPowerSwitch_q;
  logic       noPowerSwitch_d;
  logic       perPortPower_q;
  logic       perPortPower_d;
  logic       wrA;
  logic       rdA;
  logic [31:0] regImage;

  // decode works on the whole word only; there are no byte lanes
  // only command codes are decoded; hub address decode stays with the driver
  assign wrA = cmd.valid && (cmd.code == URHD_WR_DESC_A);
  assign rdA = cmd.valid && (cmd.code == URHD_RD_DESC_A);

  // next values; read-only and reserved bits are never stored at all
  always_comb begin
    waitTime_d      = waitTime_q;
    noOcProtect_d   = noOcProtect_q;
    ocPerPortMode_d = ocPerPortMode_q;
    noPowerSwitch_d = noPowerSwitch_q;
    perPortPower_d  = perPortPower_q;
    if (wrA) begin
      waitTime_d      = cmd.data[URHD_WAIT_MSB:URHD_WAIT_LSB];
      noOcProtect_d   = cmd.data[URHD_NOOC_BIT];
      ocPerPortMode_d = cmd.data[URHD_OCPP_BIT];
      noPowerSwitch_d = cmd.data[URHD_NOPS_BIT];
      perPortPower_d  = cmd.data[URHD_PPPM_BIT];
    end
  end

  // register stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      waitTime_q      <= URHD_WAIT_RST;
      noOcProtect_q   <= URHD_NOOC_RST;
      ocPerPortMode_q <= URHD_OCPP_RST;
      noPowerSwitch_q <= URHD_NOPS_RST;
      perPortPower_q  <= URHD_PPPM_RST;
    end else begin
      waitTime_q      <= waitTime_d;
      noOcProtect_q   <= noOcProtect_d;
      ocPerPortMode_q <= ocPerPortMode_d;
      noPowerSwitch_q <= noPowerSwitch_d;
      perPortPower_q  <= perPortPower_d;
    end
  end

  // ==================================================================
  // read image: constant fields and zero reserved bits built in
  always_comb begin
    regImage                              = 32'h0000_0000;
    regImage[URHD_WAIT_MSB:URHD_WAIT_LSB] = waitTime_q;
    regImage[URHD_NOOC_BIT]               = noOcProtect_q;
    regImage[URHD_OCPP_BIT]               = ocPerPortMode_q;
    regImage[URHD_CMPD_BIT]               = URHD_CMPD_VAL;
    regImage[URHD_NOPS_BIT]               = noPowerSwitch_q;
    regImage[URHD_PPPM_BIT]               = perPortPower_q;
    regImage[URHD_PCNT_MSB:URHD_PCNT_LSB] = URHD_PCNT_VAL;
  end

  // ==================================================================
  // read answer: one cycle after the read code, held for one cycle
  urhd_rsp_type rsp_q;
  urhd_rsp_type rsp_d;

  always_comb begin
    rsp_d.valid = rdA;
    rsp_d.data  = rdA ? regImage : 32'h0000_0000;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp = rsp_q;

  // ==================================================================
  // write grants for the other root hub registers, one-cycle pulses;
  // status and port writes outside the operational state are dropped
  urhd_grant_type grant_q;
  urhd_grant_type grant_d;

  always_comb begin
    grant_d.descB  = cmd.valid && (cmd.code == URHD_WR_DESC_B);
    grant_d.status = cmd.valid && operationalState
                     && (cmd.code == URHD_WR_STATUS);
    grant_d.port1  = cmd.valid && operationalState
                     && (cmd.code == URHD_WR_PORT1);
    grant_d.port2  = cmd.valid && operationalState
                     && (cmd.code == URHD_WR_PORT2);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      grant_q <= '0;
    end else begin
      grant_q <= grant_d;
    end
  end

  assign grant = grant_q;

  // ==================================================================
  // decoded modes for port power and overcurrent logic; taken from the next
  // field values so that they switch on the same edge as the fields
  logic ocReportEn_q;
  logic ocReportEn_d;
  logic ocPerPort_q;
  logic ocPerPort_d;
  logic alwaysPowered_q;
  logic alwaysPowered_d;
  logic portPowerEn_q;
  logic portPowerEn_d;

  // per-port overcurrent means nothing without reporting, so it is masked here
  always_comb begin
    ocReportEn_d    = !noOcProtect_d;
    ocPerPort_d     = !noOcProtect_d && ocPerPortMode_d;
    alwaysPowered_d = noPowerSwitch_d;
    portPowerEn_d   = !noPowerSwitch_d && perPortPower_d;
  end

  // mode flops load the decode of the field reset values
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ocReportEn_q    <= !URHD_NOOC_RST;
      ocPerPort_q     <= !URHD_NOOC_RST && URHD_OCPP_RST;
      alwaysPowered_q <= URHD_NOPS_RST;
      portPowerEn_q   <= !URHD_NOPS_RST && URHD_PPPM_RST;
    end else begin
      ocReportEn_q    <= ocReportEn_d;
      ocPerPort_q     <= ocPerPort_d;
      alwaysPowered_q <= alwaysPowered_d;
      portPowerEn_q   <= portPowerEn_d;
    end
  end

  assign powerGoodWaitTime   = waitTime_q;
  assign overcurrentReportEn = ocReportEn_q;
  assign overcurrentPerPort  = ocPerPort_q;
  assign portsAlwaysPowered  = alwaysPowered_q;
  assign perPortPowerEn      = portPowerEn_q;
  assign downstreamPortCount = URHD_PCNT_VAL;

  // ==================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_write_a;
    cmd.valid && cmd.code == URHD_WR_DESC_A;
  endsequence

  sequence s_read_a;
    cmd.valid && cmd.code == URHD_RD_DESC_A;
  endsequence

  a_write_then_read: assert property (s_write_a ##1 s_read_a |=>
    rsp.valid && rsp.data[URHD_WAIT_MSB:URHD_WAIT_LSB]
      == $past(cmd.data[URHD_WAIT_MSB:URHD_WAIT_LSB], 2))
    else $error("wait time not read back after write");
  a_read_answer_time: assert property (s_read_a |=> rsp.valid ##1
    rsp.valid == $past(cmd.valid && cmd.code == URHD_RD_DESC_A))
    else $error("read answer timing wrong");
  a_reset_values: assert property (disable iff (1'b0) $fell(sys_rst) |->
    waitTime_q == 8'hff && ocPerPortMode_q && perPortPower_q && !noOcProtect_q
    && !noPowerSwitch_q)
    else $error("reset values wrong");
  a_const_fields: assert property (rsp.valid |->
    rsp.data[URHD_CMPD_BIT] == 1'b0 && rsp.data[1:0] == 2'h2)
    else $error("read-only fields wrong");
  a_reserved_zero: assert property (rsp.valid |-> (rsp.data & ~URHD_WR_MASK
    & ~32'h0000_0003) == 32'h0000_0000)
    else $error("reserved bits not zero");
  a_oc_report: assert property (s_write_a ##1 !wrA |->
    overcurrentPerPort == (!$past(cmd.data[12]) && $past(cmd.data[11])))
    else $error("overcurrent mode decode wrong");
  a_power_mode: assert property (s_write_a |=>
    perPortPowerEn == (!$past(cmd.data[9]) && $past(cmd.data[8]))
    && portsAlwaysPowered == $past(cmd.data[9]))
    else $error("power mode decode wrong");
  a_status_gate: assert property (cmd.valid && cmd.code == URHD_WR_STATUS
    |=> grant.status == $past(operationalState))
    else $error("status write gating wrong");
  a_descb_always: assert property (cmd.valid && cmd.code == URHD_WR_DESC_B
    |=> grant.descB)
    else $error("descriptor B write refused");
  a_hold_no_write: assert property (!wrA && !sys_rst |=> $stable(waitTime_q))
    else $error("wait time changed without write");

endmodule : urhd_regs

/* File: testbench/urhd_regs_tb.sv */
// self-checking bench for the root hub characteristic register block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module urhd_regs_tb;
  import urhd_pkg::*;
  // ==================================================================
  // signals
  logic           mclk;
  logic           sys_rst;
  urhd_cmd_type   cmd;
  logic           operationalState;
  urhd_rsp_type   rsp;
  urhd_grant_type grant;
  logic [7:0]     powerGoodWaitTime;
  logic           overcurrentReportEn;
  logic           overcurrentPerPort;
  logic           portsAlwaysPowered;
  logic           perPortPowerEn;
  logic [1:0]     downstreamPortCount;
  int             errors;
  int             compares;

  urhd_regs i_urhd_regs (
    .mclk(mclk), .sys_rst(sys_rst), .cmd(cmd), .operationalState(operationalState),
    .rsp(rsp), .grant(grant), .powerGoodWaitTime(powerGoodWaitTime),
    .overcurrentReportEn(overcurrentReportEn), .overcurrentPerPort(overcurrentPerPort),
    .portsAlwaysPowered(portsAlwaysPowered), .perPortPowerEn(perPortPowerEn),
    .downstreamPortCount(downstreamPortCount)
  );

  // ==================================================================
  // clock, 20 ns period
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ==================================================================
  // tasks
  // one command cycle; answers are registered, so they are settled on return
  task automatic send(input logic [7:0] c, input logic [31:0] d);
    @(posedge mclk);
    cmd <= '{1'b1, c, d};
    @(posedge mclk);
    cmd <= '0;
    #1;
  endtask : send

  task automatic read_a(input logic [31:0] exp);
    send(URHD_RD_DESC_A, 32'h0);
    `CHK("rsp valid", 1'b1, rsp.valid)
    `CHK("rsp data", exp, rsp.data)
  endtask : read_a

  // power-up: reset image, then the per-port overcurrent bit cleared and set again
  task automatic t_power_up;
    read_a(32'hff00_0902);
    `CHK("ports", 2'h2, downstreamPortCount)
    `CHK("reset fields", 4'hd, {overcurrentReportEn, overcurrentPerPort,
      portsAlwaysPowered, perPortPowerEn})
    send(URHD_WR_DESC_A, 32'hff00_0100);
    `CHK("oc per port clear", 1'b0, overcurrentPerPort)
    send(URHD_WR_DESC_A, 32'hff00_0900);
    `CHK("oc per port set", 1'b1, overcurrentPerPort)
    read_a(32'hff00_0902);
  endtask : t_power_up

  // write table: field outputs and readback for awkward words
  task automatic t_writes;
    logic [31:0] wr [4];
    logic [31:0] rd [4];
    logic [3:0]  fl [4];
    wr = '{32'hffff_ffff, 32'h0, 32'h12fe_0900, 32'h0000_0c00};
    rd = '{32'hff00_1b02, 32'h0000_0002, 32'h1200_0902, 32'h0000_0802};
    fl = '{4'h2, 4'h8, 4'hd, 4'hc};
    for (int i = 0; i < 4; i++) begin
      send(URHD_WR_DESC_A, wr[i]);
      `CHK("write rsp", 1'b0, rsp.valid)
      `CHK("wait time", rd[i][31:24], powerGoodWaitTime)
      `CHK("fields", fl[i], {overcurrentReportEn, overcurrentPerPort,
        portsAlwaysPowered, perPortPowerEn})
      read_a(rd[i]);
    end
  endtask : t_writes

  // write grants in and out of the operational state, unknown code
  task automatic t_grants;
    for (int op = 0; op < 2; op++) begin
      @(posedge mclk);
      operationalState <= op[0];
      for (int i = 0; i < 4; i++) begin
        send(URHD_WR_DESC_B + 8'(i), 32'h0);
        `CHK("grant", (op == 1 || i == 0) ? 4'h8 >> i : 4'h0, grant)
      end
    end
    send(8'h13, 32'h0);
    `CHK("unknown", 5'h0, {rsp.valid, grant})
  endtask : t_grants

  // write then read back to back, then reset in mid-run
  task automatic t_b2b_reset;
    @(posedge mclk);
    cmd <= '{1'b1, URHD_WR_DESC_A, 32'h5500_0000};
    @(posedge mclk);
    cmd <= '{1'b1, URHD_RD_DESC_A, 32'h0};
    @(posedge mclk);
    cmd <= '0;
    #1;
    `CHK("b2b valid", 1'b1, rsp.valid)
    `CHK("b2b read", 32'h5500_0002, rsp.data)
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    `CHK("rst answer", 5'h0, {rsp.valid, grant})
    read_a(32'hff00_0902);
    `CHK("rst fields", 4'hd, {overcurrentReportEn, overcurrentPerPort,
      portsAlwaysPowered, perPortPowerEn})
  endtask : t_b2b_reset

  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // ==================================================================
  // main sequence: reset held 16 cycles, then each scenario
  initial begin
    errors = 0;
    compares = 0;
    sys_rst = 1'b1;
    cmd = '0;
    operationalState = 1'b0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_power_up();
    t_writes();
    t_grants();
    t_b2b_reset();
    close_out();
  end

  // watchdog: the run needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge mclk);
    errors++;
    close_out();
  end
endmodule : urhd_regs_tb
